// *** core/ppmc_core.v ***
// Parallel port mode control: master cycle timing, slave buffers, irq and address stepping
// Behaviour
// - Mode register bit 15 reads 1 while a master transfer runs, else 0.
// - Selection 01 interrupts at end of each cycle; 00 never interrupts.
// - Selection 10 interrupts on fourth buffer access or slave address 11.
// - Step 01 adds one to address bits 10:2 and 14 per cycle.
// - Step 10 subtracts one from address bits 10:2 and 14 per cycle.
// - Step 00 leaves the address unchanged.
// - Step 11 advances slave buffer pointers per access, legacy mode only.
// - Bit 14 used as chip select is excluded from stepping.
// - Mode 11 master drives select, direction, enable, address and data.
// - Mode 10 master drives select, read, write, address and data.
// - Mode 01 enhanced slave: host strobes, select, two address bits, data.
// - Mode 00 legacy slave: host strobes and select, data, no address.
// - Setup wait is field plus one periods, default one.
// - Strobe lasts strobe field plus one periods, one to sixteen.
// - Strobe field 0000 forces setup one, hold one write, zero read.
//
// Design decisions made here: the strobed register port and the register addresses.
`timescale 1ns/10ps
`include "ppmc_consts.vh"
module ppmc_core (
	input  wire        clk,
	input  wire        rst,
	input  wire [7:0]  regAddr,
	input  wire [31:0] regWdata,
	input  wire        regWr,
	input  wire        regRd,
	output reg  [31:0] regRdata,
	output wire        irq,
	output reg         csOut,
	output reg         rdOut,
	output reg         wrOut,
	output wire [15:0] addrOut,
	output reg  [7:0]  dataOut,
	output reg         dataOe,
	input  wire [7:0]  dataIn,
	input  wire        hostCs,
	input  wire        hostRd,
	input  wire        hostWr,
	input  wire [1:0]  hostAddr
);
	localparam [3:0] ST_IDLE   = 4'h1;
	localparam [3:0] ST_SETUP  = 4'h2;
	localparam [3:0] ST_STROBE = 4'h4;
	localparam [3:0] ST_HOLD   = 4'h8;

	reg  [15:0] mode_r;
	reg  [15:0] addr_r;
	reg  [7:0]  rdData_r;
	reg  [7:0]  wrData_r;
	reg  [1:0]  stat_r;
	reg  [1:0]  mask_r;
	reg         cs1En_r;
	reg  [3:0]  state_r;
	reg  [3:0]  cnt_r;
	reg         isRead_r;
	reg  [7:0]  rBuf_r [0:3];
	reg  [7:0]  wBuf_r [0:3];
	reg  [1:0]  rPtr_r;
	reg  [1:0]  wPtr_r;
	reg         prevRd_r;
	reg         prevWr_r;
	reg         prevCs_r;
	reg  [1:0]  prevIdx_r;
	reg  [3:0]  cnt_nxt;
	reg  [3:0]  state_nxt;

	wire [1:0] irqSel   = mode_r[`PPMC_IRQ_HI:`PPMC_IRQ_LO];
	wire [1:0] stepSel  = mode_r[`PPMC_STEP_HI:`PPMC_STEP_LO];
	wire [1:0] portMode = mode_r[`PPMC_MODE_HI:`PPMC_MODE_LO];
	wire [1:0] setupF   = mode_r[`PPMC_SETUP_HI:`PPMC_SETUP_LO];
	wire [3:0] strbF    = mode_r[`PPMC_STRB_HI:`PPMC_STRB_LO];
	wire [1:0] holdF    = mode_r[`PPMC_HOLD_HI:`PPMC_HOLD_LO];
	wire       master   = portMode[1];
	wire       busy     = (state_r != ST_IDLE);
	wire       fastMode = (strbF == `PPMC_STRB_MIN);

	// Sticky flag: set wins over a write-one clear
	function stickyNext;
		input flag;
		input evt;
		input clr;
		begin
			stickyNext = evt || (flag && !clr);
		end
	endfunction

	// Last count of a phase that lasts len periods
	function phaseEnd;
		input [3:0] cnt;
		input [3:0] len;
		begin
			phaseEnd = (cnt + 4'h1 >= len);
		end
	endfunction

	// Word-aligned register address inside a four-entry buffer bank
	function bufHit;
		input [7:0] a;
		input [7:0] base;
		begin
			bufHit = (a[7:4] == base[7:4]) && (a[1:0] == 2'h0);
		end
	endfunction

	// Setup and hold lengths in peripheral-clock periods
	wire [3:0] setupLen = fastMode ? 4'h1 : {2'h0, setupF} + 4'h1;
	wire [3:0] holdLen  = fastMode ? (isRead_r ? 4'h0 : 4'h1) : {2'h0, holdF};
	wire [3:0] strbLen  = strbF;

	// Register write decode
	wire wrMode = regWr && (regAddr == `PPMC_OFF_MODE);
	wire wrAddr = regWr && (regAddr == `PPMC_OFF_ADDR);
	wire wrData = regWr && (regAddr == `PPMC_OFF_DATA);
	wire wrStat = regWr && (regAddr == `PPMC_OFF_STAT);
	wire wrMask = regWr && (regAddr == `PPMC_OFF_MASK);
	wire wrCtrl = regWr && (regAddr == `PPMC_OFF_CTRL);
	wire wrRBuf = regWr && bufHit(regAddr, `PPMC_OFF_RBUF);

	// Transfer starts only in master mode while idle
	wire goWrite = wrData && master && !busy;
	wire goRead  = wrCtrl && regWdata[`PPMC_CTRL_READ] && master && !busy;
	wire cycDone = (state_r != ST_IDLE) && (state_nxt == ST_IDLE);

	// Slave buffer index for the current host access
	wire [1:0] slvRdIdx = (portMode == `PPMC_PM_ENH) ? hostAddr :
		((stepSel == `PPMC_STEP_BUF) ? rPtr_r : 2'h0);
	wire [1:0] slvWrIdx = (portMode == `PPMC_PM_ENH) ? hostAddr :
		((stepSel == `PPMC_STEP_BUF) ? wPtr_r : 2'h0);
	wire slave    = !master;
	wire slvRdEnd = slave && prevCs_r && prevRd_r && !(hostRd && hostCs);
	wire slvWrEnd = slave && prevCs_r && prevWr_r && !(hostWr && hostCs);
	wire slvEnd   = slvRdEnd || slvWrEnd;

	// Buffer-class event
	wire bufEvt = slvEnd && (prevIdx_r == `PPMC_LAST_BUF) &&
		((portMode == `PPMC_PM_ENH) || (stepSel == `PPMC_STEP_BUF));
	wire evCycle = (irqSel == `PPMC_IRQ_CYCLE) && (cycDone || slvEnd);
	wire evBuf   = (irqSel == `PPMC_IRQ_BUF) && bufEvt;

	// Address stepping over bits 10:2 with bit 14 on top
	function [15:0] stepAddr;
		input [15:0] a;
		input        down;
		input        keep14;
		reg   [9:0]  f;
		reg   [9:0]  n;
		begin
			f = {a[14], a[10:2]};
			n = down ? f - 10'h001 : f + 10'h001;
			stepAddr = a;
			stepAddr[10:2] = n[8:0];
			if (!keep14) begin
				stepAddr[14] = n[9];
			end
		end
	endfunction

	// Master timing state machine
	always @* begin
		state_nxt = state_r;
		cnt_nxt = cnt_r;
		case (state_r)
			ST_IDLE: begin
				if (goWrite || goRead) begin
					state_nxt = ST_SETUP;
					cnt_nxt = 4'h0;
				end
			end
			ST_SETUP: begin
				if (phaseEnd(cnt_r, setupLen)) begin
					state_nxt = ST_STROBE;
					cnt_nxt = 4'h0;
				end else begin
					cnt_nxt = cnt_r + 4'h1;
				end
			end
			ST_STROBE: begin
				if (cnt_r == strbLen) begin
					cnt_nxt = 4'h0;
					state_nxt = (holdLen == 4'h0) ? ST_IDLE : ST_HOLD;
				end else begin
					cnt_nxt = cnt_r + 4'h1;
				end
			end
			ST_HOLD: begin
				if (phaseEnd(cnt_r, holdLen)) begin
					state_nxt = ST_IDLE;
					cnt_nxt = 4'h0;
				end else begin
					cnt_nxt = cnt_r + 4'h1;
				end
			end
			default: begin
				state_nxt = ST_IDLE;
				cnt_nxt = 4'h0;
			end
		endcase
	end

	always @(posedge clk) begin
		if (rst) begin
			state_r <= ST_IDLE;
			cnt_r <= 4'h0;
			isRead_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
			if (state_r == ST_IDLE) begin
				isRead_r <= goRead;
			end
		end
	end

	// Configuration, address, data and status registers
	always @(posedge clk) begin
		if (rst) begin
			mode_r <= `PPMC_MODE_RST;
			addr_r <= 16'h0000;
			wrData_r <= 8'h00;
			rdData_r <= 8'h00;
			stat_r <= 2'h0;
			mask_r <= 2'h0;
			cs1En_r <= 1'b0;
		end else begin
			if (wrMode) begin
				mode_r <= regWdata[15:0] & `PPMC_MODE_WMASK;
			end
			if (wrCtrl) begin
				cs1En_r <= regWdata[`PPMC_CTRL_CS1];
			end
			if (goWrite) begin
				wrData_r <= regWdata[7:0];
			end
			if (state_r == ST_STROBE && state_nxt != ST_STROBE && isRead_r) begin
				rdData_r <= dataIn;
			end
			if (wrAddr) begin
				addr_r <= regWdata[15:0];
			end else if (cycDone) begin
				case (stepSel)
					`PPMC_STEP_UP: addr_r <= stepAddr(addr_r, 1'b0, cs1En_r);
					`PPMC_STEP_DOWN: addr_r <= stepAddr(addr_r, 1'b1, cs1En_r);
					default: addr_r <= addr_r;
				endcase
			end
			if (wrMask) begin
				mask_r <= regWdata[`PPMC_ST_W-1:0];
			end
			// Set wins over a simultaneous write-one clear
			stat_r[`PPMC_ST_CYCLE] <= stickyNext(stat_r[`PPMC_ST_CYCLE], evCycle,
				wrStat && regWdata[`PPMC_ST_CYCLE]);
			stat_r[`PPMC_ST_BUF] <= stickyNext(stat_r[`PPMC_ST_BUF], evBuf,
				wrStat && regWdata[`PPMC_ST_BUF]);
		end
	end

	// Level interrupt while an unmasked status bit is set
	assign irq = |(stat_r & mask_r);

	// Slave buffers and pointers
	always @(posedge clk) begin
		if (rst) begin
			rPtr_r <= 2'h0;
			wPtr_r <= 2'h0;
			prevRd_r <= 1'b0;
			prevWr_r <= 1'b0;
			prevCs_r <= 1'b0;
			prevIdx_r <= 2'h0;
			rBuf_r[0] <= 8'h00;
			rBuf_r[1] <= 8'h00;
			rBuf_r[2] <= 8'h00;
			rBuf_r[3] <= 8'h00;
			wBuf_r[0] <= 8'h00;
			wBuf_r[1] <= 8'h00;
			wBuf_r[2] <= 8'h00;
			wBuf_r[3] <= 8'h00;
		end else begin
			prevRd_r <= hostRd;
			prevWr_r <= hostWr;
			prevCs_r <= hostCs;
			prevIdx_r <= hostRd ? slvRdIdx : slvWrIdx;
			if (wrRBuf) begin
				rBuf_r[regAddr[3:2]] <= regWdata[7:0];
			end
			if (slave && hostCs && hostWr) begin
				wBuf_r[slvWrIdx] <= dataIn;
			end
			// Buffered legacy mode steps the pointers at access end
			if (portMode == `PPMC_PM_LEGACY && stepSel == `PPMC_STEP_BUF) begin
				if (slvRdEnd) begin
					rPtr_r <= rPtr_r + 2'h1;
				end
				if (slvWrEnd) begin
					wPtr_r <= wPtr_r + 2'h1;
				end
			end else begin
				rPtr_r <= 2'h0;
				wPtr_r <= 2'h0;
			end
		end
	end

	// Pin drive
	// Bit 14 carries chip select when so configured
	assign addrOut = cs1En_r ? {addr_r[15], csOut, addr_r[13:0]} : addr_r;

	always @(posedge clk) begin
		if (rst) begin
			csOut <= 1'b0;
			rdOut <= 1'b0;
			wrOut <= 1'b0;
			dataOut <= 8'h00;
			dataOe <= 1'b0;
		end else if (master) begin
			csOut <= (state_nxt != ST_IDLE);
			if (portMode == `PPMC_PM_MASTER1) begin
				rdOut <= (state_nxt != ST_IDLE) && isRdNext(state_r, goRead, isRead_r);
				wrOut <= (state_nxt == ST_STROBE);
			end else begin
				rdOut <= (state_nxt == ST_STROBE) && isRdNext(state_r, goRead, isRead_r);
				wrOut <= (state_nxt == ST_STROBE) && !isRdNext(state_r, goRead, isRead_r);
			end
			dataOut <= goWrite ? regWdata[7:0] : wrData_r;
			dataOe <= (state_nxt != ST_IDLE) && !isRdNext(state_r, goRead, isRead_r);
		end else begin
			csOut <= 1'b0;
			rdOut <= 1'b0;
			wrOut <= 1'b0;
			dataOut <= rBuf_r[slvRdIdx];
			dataOe <= hostCs && hostRd;
		end
	end

	// Direction of the cycle in flight or about to start
	function isRdNext;
		input [3:0] st;
		input       go;
		input       held;
		begin
			isRdNext = (st == ST_IDLE) ? go : held;
		end
	endfunction

	// Register read port, data one cycle after the strobe
	always @(posedge clk) begin
		if (rst) begin
			regRdata <= 32'h00000000;
		end else if (regRd) begin
			case (regAddr)
				`PPMC_OFF_MODE: regRdata <= {16'h0000, busy, mode_r[14:0]};
				`PPMC_OFF_ADDR: regRdata <= {16'h0000, addr_r};
				`PPMC_OFF_DATA: regRdata <= {24'h000000, rdData_r};
				`PPMC_OFF_STAT: regRdata <= {30'h00000000, stat_r};
				`PPMC_OFF_MASK: regRdata <= {30'h00000000, mask_r};
				`PPMC_OFF_CTRL: regRdata <= {30'h00000000, cs1En_r, 1'b0};
				default: begin
					if (bufHit(regAddr, `PPMC_OFF_RBUF)) begin
						regRdata <= {24'h000000, rBuf_r[regAddr[3:2]]};
					end else if (bufHit(regAddr, `PPMC_OFF_WBUF)) begin
						regRdata <= {24'h000000, wBuf_r[regAddr[3:2]]};
					end else begin
						regRdata <= 32'h00000000;
					end
				end
			endcase
		end else begin
			regRdata <= 32'h00000000;
		end
	end
endmodule

// *** inc/ppmc_consts.vh ***
// Offsets, field positions, reset values and timing constants of the parallel port
`ifndef PPMC_CONSTS_VH
`define PPMC_CONSTS_VH
`define PPMC_CLK_MHZ        25
`define PPMC_PERIOD_NS      40
// Register byte offsets
`define PPMC_OFF_MODE       8'h00
`define PPMC_OFF_ADDR       8'h04
`define PPMC_OFF_DATA       8'h08
`define PPMC_OFF_STAT       8'h0c
`define PPMC_OFF_MASK       8'h10
`define PPMC_OFF_CTRL       8'h14
`define PPMC_OFF_RBUF       8'h20
`define PPMC_OFF_WBUF       8'h30
// Mode register fields
`define PPMC_BUSY_BIT       15
`define PPMC_IRQ_HI         14
`define PPMC_IRQ_LO         13
`define PPMC_STEP_HI        12
`define PPMC_STEP_LO        11
`define PPMC_MODE_HI        9
`define PPMC_MODE_LO        8
`define PPMC_SETUP_HI       7
`define PPMC_SETUP_LO       6
`define PPMC_STRB_HI        5
`define PPMC_STRB_LO        2
`define PPMC_HOLD_HI        1
`define PPMC_HOLD_LO        0
`define PPMC_MODE_RST       16'h0000
`define PPMC_MODE_WMASK     16'h7bff
// Field encodings
`define PPMC_IRQ_NONE       2'h0
`define PPMC_IRQ_CYCLE      2'h1
`define PPMC_IRQ_BUF        2'h2
`define PPMC_STEP_NONE      2'h0
`define PPMC_STEP_UP        2'h1
`define PPMC_STEP_DOWN      2'h2
`define PPMC_STEP_BUF       2'h3
`define PPMC_PM_LEGACY      2'h0
`define PPMC_PM_ENH         2'h1
`define PPMC_PM_MASTER2     2'h2
`define PPMC_PM_MASTER1     2'h3
`define PPMC_STRB_MIN       4'h0
`define PPMC_LAST_BUF       2'h3
// Control register bits
`define PPMC_CTRL_READ      0
`define PPMC_CTRL_CS1       1
// Status register bits
`define PPMC_ST_CYCLE       0
`define PPMC_ST_BUF         1
`define PPMC_ST_W           2
`endif

// *** tb/ppmc_core_asserts.sv ***
// Checker for master pin timing of the parallel port
`timescale 1ns/10ps
module ppmc_core_asserts (
	input wire        clk,
	input wire        rst,
	input wire        csOut,
	input wire        rdOut,
	input wire        wrOut,
	input wire [15:0] addrOut,
	input wire [7:0]  dataOut,
	input wire        dataOe
);
	reg [4:0] strbCnt_r;

	// Length of the current strobe run
	always @(posedge clk) begin
		if (rst) strbCnt_r <= 5'h0;
		else strbCnt_r <= wrOut ? strbCnt_r + 5'h1 : 5'h0;
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	chk_wr_in_cs: assert property (wrOut |-> csOut)
		else $error("strobe outside chip select");
	chk_rd_in_cs: assert property (rdOut |-> csOut)
		else $error("read line outside chip select");
	chk_setup_first: assert property ($rose(csOut) |-> !wrOut)
		else $error("strobe without setup period");
	chk_cs_min: assert property ($rose(csOut) |-> csOut[*2])
		else $error("cycle shorter than setup and strobe");
	chk_strobe_max: assert property (strbCnt_r <= 5'h10)
		else $error("strobe longer than sixteen periods");
	chk_addr_hold: assert property (csOut && $past(csOut) |-> $stable(addrOut))
		else $error("address moved inside cycle");
	chk_data_hold: assert property (dataOe && csOut && $past(dataOe && csOut)
		|-> $stable(dataOut))
		else $error("write data moved inside cycle");
	chk_oe_dir: assert property (csOut && dataOe |-> !rdOut)
		else $error("data driven during read");
endmodule

bind ppmc_core ppmc_core_asserts i_chk (.clk, .rst, .csOut, .rdOut, .wrOut, .addrOut,
	.dataOut, .dataOe);

// *** tb/ppmc_core_tb.sv ***
// Testbench of the parallel port mode control
`timescale 1ns/10ps
`include "ppmc_consts.vh"
`define CHK(a, b) begin checksDone = checksDone + 1; if ((a) !== (b)) begin \
	mismatches = mismatches + 1; $display("Error t=%0t got %h exp %h", $time, (a), (b)); end end
module ppmc_core_tb;
	reg         clk, rst, regWr, regRd, hostCs, hostRd, hostWr, hostDrive;
	reg  [7:0]  regAddr, hostByte;
	reg  [31:0] regWdata, d;
	reg  [1:0]  hostAddr;
	wire [31:0] regRdata;
	wire [15:0] addrOut;
	wire [7:0]  dataOut, dataIn;
	wire        irq, csOut, rdOut, wrOut, dataOe;
	integer     mismatches = 0, checksDone = 0, su, st, rs, tot;

	ppmc_core i_dut (.clk, .rst, .regAddr, .regWdata, .regWr, .regRd, .regRdata, .irq,
		.csOut, .rdOut, .wrOut, .addrOut, .dataOut, .dataOe, .dataIn, .hostCs, .hostRd,
		.hostWr, .hostAddr);
	ppmc_periph i_periph (.clk, .csOut, .rdOut, .dataOe, .hostDrive, .hostByte, .dataIn);

	always #20 clk = ~clk;

	// Never builds interrupt selection 11
	function [31:0] md(input [1:0] q, s, p, b, input [3:0] m, input [1:0] e);
		md = {17'h0, q, s, 1'b0, p, b, m, e};
	endfunction
	task endOfTest;
		if (mismatches == 0 && checksDone > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	task wr(input [7:0] a, input [31:0] v);
		@(posedge clk);
		regAddr <= a;
		regWdata <= v;
		regWr <= 1'b1;
		@(posedge clk);
		regWr <= 1'b0;
	endtask
	task rd(input [7:0] a);
		@(posedge clk);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge clk);
		regRd <= 1'b0;
		#1 d = regRdata;
	endtask
	// Follows one master cycle to its end
	task cyc;
		integer n;
		su = 0;
		st = 0;
		rs = 0;
		tot = 0;
		for (n = 0; n < 100; n = n + 1) begin
			#1;
			if (csOut === 1'b1) begin
				tot = tot + 1;
				if (rdOut === 1'b1) rs = rs + 1;
				if (wrOut === 1'b1) st = st + 1;
				else if (st == 0) su = su + 1;
			end else if (tot > 0) n = 200;
			if (n < 200) @(posedge clk);
		end
		if (n < 200) begin
			mismatches = mismatches + 1;
			endOfTest;
		end
	endtask
	task host(input [1:0] a, input w, input [7:0] b, e);
		@(posedge clk);
		hostAddr <= a;
		hostWr <= w;
		hostRd <= !w;
		hostDrive <= w;
		hostByte <= b;
		hostCs <= 1'b1;
		@(posedge clk);
		{hostCs, hostWr, hostRd, hostDrive} <= 4'h0;
		#1 if (!w) begin
			`CHK(dataOe, 1'b1)
			`CHK(dataOut, e)
		end
		@(posedge clk);
	endtask

	task s_write;
		wr(`PPMC_OFF_MASK, 32'h3);
		wr(`PPMC_OFF_MODE, md(2'h1, 2'h1, 2'h2, 2'h0, 4'h1, 2'h1));
		wr(`PPMC_OFF_ADDR, 32'h7fc);
		wr(`PPMC_OFF_DATA, 32'ha5);
		cyc;
		`CHK(su, 1)
		`CHK(st, 2)
		`CHK(tot, 4)
		`CHK(dataOut, 8'ha5)
		`CHK(dataOe, 1'b0)
		`CHK(irq, 1'b1)
		rd(`PPMC_OFF_ADDR);
		`CHK(d, 32'h4000)
		rd(`PPMC_OFF_STAT);
		`CHK(d, 32'h1)
		wr(`PPMC_OFF_STAT, 32'h1);
		#1 `CHK(irq, 1'b0)
		rd(`PPMC_OFF_MODE);
		`CHK(d[15], 1'b0)
	endtask
	task s_read;
		wr(`PPMC_OFF_MODE, md(2'h0, 2'h2, 2'h3, 2'h0, 4'h0, 2'h0));
		wr(`PPMC_OFF_ADDR, 32'h4000);
		wr(`PPMC_OFF_CTRL, 32'h1);
		cyc;
		`CHK(tot, 2)
		`CHK(rs, 2)
		rd(`PPMC_OFF_DATA);
		`CHK(d[7:0], 8'h3c)
		rd(`PPMC_OFF_ADDR);
		`CHK(d, 32'h7fc)
		rd(`PPMC_OFF_STAT);
		`CHK(d, 32'h0)
		wr(`PPMC_OFF_MODE, md(2'h0, 2'h0, 2'h3, 2'h3, 4'h0, 2'h3));
		wr(`PPMC_OFF_DATA, 32'h5a);
		cyc;
		`CHK(su, 1)
		`CHK(tot, 3)
		rd(`PPMC_OFF_ADDR);
		`CHK(d, 32'h7fc)
	endtask
	task s_long;
		wr(`PPMC_OFF_CTRL, 32'h2);
		wr(`PPMC_OFF_MODE, md(2'h0, 2'h1, 2'h2, 2'h3, 4'hf, 2'h3));
		wr(`PPMC_OFF_DATA, 32'h1);
		rd(`PPMC_OFF_MODE);
		`CHK(d[15], 1'b1)
		`CHK(addrOut[14], 1'b1)
		cyc;
		`CHK(st, 16)
		`CHK(tot, 21)
		rd(`PPMC_OFF_ADDR);
		`CHK(d, 32'h0)
	endtask
	task s_slave;
		wr(`PPMC_OFF_MODE, md(2'h2, 2'h0, 2'h1, 2'h0, 4'h0, 2'h0));
		host(2'h3, 1'b1, 8'h5a, 8'h0);
		rd(8'h3c);
		`CHK(d[7:0], 8'h5a)
		rd(`PPMC_OFF_STAT);
		`CHK(d, 32'h2)
		`CHK(irq, 1'b1)
		wr(`PPMC_OFF_STAT, 32'h2);
		wr(8'h2c, 32'h77);
		host(2'h3, 1'b0, 8'h0, 8'h77);
		rd(`PPMC_OFF_STAT);
		`CHK(d, 32'h2)
		wr(`PPMC_OFF_MODE, md(2'h0, 2'h3, 2'h0, 2'h0, 4'h0, 2'h0));
		host(2'h3, 1'b1, 8'h11, 8'h0);
		host(2'h3, 1'b1, 8'h22, 8'h0);
		rd(8'h30);
		`CHK(d[7:0], 8'h11)
		rd(8'h34);
		`CHK(d[7:0], 8'h22)
		wr(8'h20, 32'h12);
		wr(8'h24, 32'h34);
		host(2'h0, 1'b0, 8'h0, 8'h12);
		host(2'h0, 1'b0, 8'h0, 8'h34);
	endtask
	task s_rd2;
		wr(`PPMC_OFF_MODE, md(2'h1, 2'h0, 2'h2, 2'h1, 4'h2, 2'h2));
		wr(`PPMC_OFF_CTRL, 32'h3);
		cyc;
		`CHK(tot, 7)
		`CHK(rs, 3)
		`CHK(st, 0)
		rd(`PPMC_OFF_DATA);
		`CHK(d[7:0], 8'h3c)
		rd(`PPMC_OFF_STAT);
		`CHK(d, 32'h1)
		wr(`PPMC_OFF_STAT, 32'h1);
	endtask

	initial begin
		{clk, rst, regWr, regRd, hostCs, hostRd, hostWr, hostDrive} = 8'h40;
		{regAddr, hostByte, hostAddr, regWdata} = 50'h0;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		rd(`PPMC_OFF_MODE);
		`CHK(d, 32'h0)
		rd(8'h44);
		`CHK(d, 32'h0)
		s_write;
		s_read;
		s_long;
		s_rd2;
		s_slave;
		endOfTest;
	end
endmodule

// *** tb/ppmc_periph.sv ***
// Far side of the port: peripheral answering reads and host byte source
`timescale 1ns/10ps
module ppmc_periph (
	input  wire       clk,
	input  wire       csOut,
	input  wire       rdOut,
	input  wire       dataOe,
	input  wire       hostDrive,
	input  wire [7:0] hostByte,
	output wire [7:0] dataIn
);
	localparam [7:0] ANSWER = 8'h3c;
	reg flip_r = 1'b0;

	always @(posedge clk) flip_r <= ~flip_r;
	// Released bus shows a changing pattern
	assign dataIn = hostDrive ? hostByte :
		(csOut && rdOut && !dataOe) ? ANSWER : {4{flip_r, ~flip_r}};
endmodule
